// >>> design/dss_startup_host.sv
// Function
// - After power-up the host configures the converter over its serial port by an ordered list of accesses.
// - The converter has its own power-on and pin reset, so the software reset step may be skipped.
// - Multichip synchronisation is only for several devices, with matched data clock delay values, and is not run.
// - The delay-lock controller is enabled and tracking before the data receiver controller is enabled.
// - Every wait is counted in periods of the incoming data clock, not in time.
// - Each controller lock is tried at most three times before a failure is reported.
// - Lock state is seen both through the device interrupt pin and through read-back status.
// - The first access writes serial_port_config to the serial port register, a value mirrored for either bit order.
// - Writing 0x20 to the serial port register resets the device, and serial_port_config then clears the reset bit.
// - Both clock input common-mode registers are written with 0x0F.
// - The delay-lock configuration registers get 0x30 and 0x80 by default, software may change them.
// - After delay-lock search and track the host waits 160K periods and expects 0x01 from its status.
// - After receiver search and track it waits 135K periods, expects 0x09, else advances the divider phase.
`timescale 1ns/1ps
`default_nettype none
module dss_startup_host #(
  parameter int DL_WAIT = dss_pkg::DSS_DL_WAIT_PERIODS,
  parameter int RX_WAIT = dss_pkg::DSS_RX_WAIT_PERIODS,
  parameter int MAX_TRIES = dss_pkg::DSS_MAX_TRIES,
  parameter int SPI_HALF = dss_pkg::DSS_SPI_HALF
) (
  input wire logic clk, // 40 MHz system clock
  input wire logic nrst, // async reset, low
  input wire logic ce, // clock enable
  input wire logic [3:0] reg_addr, // register address
  input wire logic [15:0] reg_wdata, // register write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [15:0] reg_rdata, // read data, one cycle later
  output logic irq, // interrupt, high
  output logic spi_sclk, // serial clock to device
  output logic spi_cs_n, // chip select, low
  output logic spi_mosi, // serial data to device
  input wire logic spi_miso, // serial data from device
  input wire logic data_clk, // data clock of the link
  input wire logic dev_irq_n // device interrupt pin, low
);
  import dss_pkg::*;

  localparam int CW = DSS_WAIT_W;

  if (MAX_TRIES < 1 || MAX_TRIES > 3) $error("MAX_TRIES must be 1 to 3");
  if (DL_WAIT < 1 || DL_WAIT >= 2**CW || RX_WAIT < 1 || RX_WAIT >= 2**CW) $error("wait out of range");

  typedef enum {S_IDLE, S_STEP, S_XFER, S_WAIT, S_PHR, S_PHW} dss_state_type;

  dss_state_type state_q, state_d;
  logic [4:0] idx_q, idx_d;
  logic [1:0] tries_q, tries_d;
  logic go_q, go_d, tgo_q, tgo_d;
  dss_spi_req_type req_q, req_d;
  logic ok_q, ok_d, dlf_q, dlf_d, rxf_q, rxf_d;
  logic skip_q;
  logic [15:0] dl_cfg_q;
  logic [7:0] rdback_q;
  logic [DSS_NEV-1:0] stat_q, en_q, ev;
  logic dirq_s1_q, dirq_s2_q, dirq_s3_q;
  logic spi_busy, spi_done;
  logic [7:0] spi_rdata;
  logic tmr_done;
  dss_step_type cur;
  logic chk_op, chk_fail, last_try, start_cmd;
  logic [CW-1:0] wait_cnt;
  logic [DSS_NEV-1:0] clr_bits;
  logic [15:0] rd_mux;

  function automatic dss_step_type step_at(input logic [4:0] i, input logic [15:0] dl);
    case (i)
      5'd0: step_at = '{OP_WR, DEV_SERIAL_PORT_CONFIG, DEV_SPCFG_4W_MSB};
      5'd1: step_at = '{OP_WR, DEV_SERIAL_PORT_CONFIG, DEV_SPCFG_SW_RESET};
      5'd2: step_at = '{OP_WR, DEV_SERIAL_PORT_CONFIG, DEV_SPCFG_4W_MSB};
      5'd3: step_at = '{OP_WR, DEV_CLOCK_INPUT_COMMON_MODE_A, DEV_CM_VAL};
      5'd4: step_at = '{OP_WR, DEV_CLOCK_INPUT_COMMON_MODE_B, DEV_CM_VAL};
      5'd5: step_at = '{OP_WR, DEV_DELAY_LOCK_CONFIG_A, dl[7:0]};
      5'd6: step_at = '{OP_WR, DEV_DELAY_LOCK_CONFIG_B, dl[15:8]};
      5'd7: step_at = '{OP_WR, DEV_DELAY_LOCK_TUNE_A, DEV_TUNE_A_VAL};
      5'd8: step_at = '{OP_WR, DEV_DELAY_LOCK_TUNE_B, DEV_TUNE_B_VAL};
      5'd9: step_at = '{OP_WR, DEV_DELAY_LOCK_TUNE_C, DEV_TUNE_C_VAL};
      5'd10: step_at = '{OP_WR, DEV_DELAY_LOCK_CTRL, DEV_DL_LOOP_VAL};
      5'd11: step_at = '{OP_WR, DEV_DELAY_LOCK_CTRL, DEV_DL_TRACK_VAL};
      5'd12: step_at = '{OP_WAIT_DL, 7'h00, 8'h00};
      5'd13: step_at = '{OP_CHK_DL, DEV_DELAY_LOCK_STATUS, DEV_DL_LOCKED};
      5'd14: step_at = '{OP_WR, DEV_RX_SKEW, DEV_RX_SKEW_VAL};
      5'd15: step_at = '{OP_WR, DEV_RX_CTRL, DEV_RX_OFF_VAL};
      5'd16: step_at = '{OP_WR, DEV_RX_CTRL, DEV_RX_LOOP_VAL};
      5'd17: step_at = '{OP_WR, DEV_RX_CTRL, DEV_RX_TRACK_VAL};
      5'd18: step_at = '{OP_WAIT_RX, 7'h00, 8'h00};
      5'd19: step_at = '{OP_CHK_RX, DEV_RX_STATUS, DEV_RX_LOCKED};
      default: step_at = '{OP_END, 7'h00, 8'h00};
    endcase
  endfunction

  assign cur = step_at(idx_q, dl_cfg_q);
  assign chk_op = (cur.op == OP_CHK_DL) || (cur.op == OP_CHK_RX);
  assign chk_fail = chk_op && (spi_rdata != cur.data);
  assign last_try = (tries_q == 2'(MAX_TRIES - 1));
  assign start_cmd = reg_wr && (reg_addr == DSS_REG_CTRL) && reg_wdata[DSS_CTRL_START] && (state_q == S_IDLE);
  assign wait_cnt = (cur.op == OP_WAIT_DL) ? CW'(DL_WAIT) : CW'(RX_WAIT);
  assign clr_bits = (reg_wr && reg_addr == DSS_REG_IRQ_CLR) ? reg_wdata[DSS_NEV-1:0] : '0;

  always_comb
  begin
    state_d = state_q;
    idx_d = idx_q;
    tries_d = tries_q;
    go_d = 1'b0;
    tgo_d = 1'b0;
    req_d = req_q;
    ok_d = ok_q;
    dlf_d = dlf_q;
    rxf_d = rxf_q;
    case (state_q)
      S_IDLE:
        if (start_cmd)
        begin
          state_d = S_STEP;
          idx_d = 5'h00;
          tries_d = 2'h0;
          ok_d = 1'b0;
          dlf_d = 1'b0;
          rxf_d = 1'b0;
        end
      S_STEP:
        case (cur.op)
          OP_WR:
            if (idx_q == DSS_IDX_SW_RESET && skip_q)
              idx_d = idx_q + 5'h01;
            else
            begin
              go_d = 1'b1;
              req_d = '{1'b0, cur.addr, cur.data};
              state_d = S_XFER;
            end
          OP_WAIT_DL, OP_WAIT_RX:
          begin
            tgo_d = 1'b1;
            state_d = S_WAIT;
          end
          OP_CHK_DL, OP_CHK_RX:
          begin
            go_d = 1'b1;
            req_d = '{1'b1, cur.addr, 8'h00};
            state_d = S_XFER;
          end
          default:
          begin
            ok_d = 1'b1;
            state_d = S_IDLE;
          end
        endcase
      S_XFER:
        if (spi_done)
        begin
          if (chk_fail && last_try)
          begin
            dlf_d = (cur.op == OP_CHK_DL);
            rxf_d = (cur.op == OP_CHK_RX);
            state_d = S_IDLE;
          end
          else if (chk_fail && cur.op == OP_CHK_DL)
          begin
            tries_d = tries_q + 2'h1;
            idx_d = DSS_IDX_DL_RETRY;
            state_d = S_STEP;
          end
          else if (chk_fail)
          begin
            tries_d = tries_q + 2'h1;
            go_d = 1'b1;
            req_d = '{1'b1, DEV_DIVIDER_PHASE, 8'h00};
            state_d = S_PHR;
          end
          else
          begin
            if (chk_op)
              tries_d = 2'h0;
            idx_d = idx_q + 5'h01;
            state_d = S_STEP;
          end
        end
      S_WAIT:
        if (tmr_done)
        begin
          idx_d = idx_q + 5'h01;
          state_d = S_STEP;
        end
      S_PHR:
        if (spi_done)
        begin
          go_d = 1'b1;
          req_d = '{1'b0, DEV_DIVIDER_PHASE, {spi_rdata[7:6] + 2'h1, spi_rdata[5:0]}};
          state_d = S_PHW;
        end
      S_PHW:
        if (spi_done)
        begin
          idx_d = DSS_IDX_RX_RETRY;
          state_d = S_STEP;
        end
      default: state_d = S_IDLE;
    endcase
  end

  // sequence results and device interrupt seen as events
  assign ev[DSS_EV_DONE] = ok_d && !ok_q;
  assign ev[DSS_EV_DL_FAIL] = dlf_d && !dlf_q;
  assign ev[DSS_EV_RX_FAIL] = rxf_d && !rxf_q;
  assign ev[DSS_EV_DEV_IRQ] = dirq_s2_q && !dirq_s3_q;

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      state_q <= S_IDLE;
      idx_q <= 5'h00;
      tries_q <= 2'h0;
      go_q <= 1'b0;
      tgo_q <= 1'b0;
      req_q <= '0;
      ok_q <= 1'b0;
      dlf_q <= 1'b0;
      rxf_q <= 1'b0;
    end
    else if (ce)
    begin
      state_q <= state_d;
      idx_q <= idx_d;
      tries_q <= tries_d;
      go_q <= go_d;
      tgo_q <= tgo_d;
      req_q <= req_d;
      ok_q <= ok_d;
      dlf_q <= dlf_d;
      rxf_q <= rxf_d;
    end

  // pin is active low, inverted before the synchroniser
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      dirq_s1_q <= 1'b0;
      dirq_s2_q <= 1'b0;
      dirq_s3_q <= 1'b0;
    end
    else if (ce)
    begin
      dirq_s1_q <= !dev_irq_n;
      dirq_s2_q <= dirq_s1_q;
      dirq_s3_q <= dirq_s2_q;
    end

  assign rd_mux = (reg_addr == DSS_REG_CTRL) ? {14'h0000, skip_q, 1'b0} :
                  (reg_addr == DSS_REG_STATUS) ? {3'h0, idx_q, 1'b0, tries_q, dirq_s2_q, rxf_q, dlf_q, ok_q,
                                                  (state_q != S_IDLE)} :
                  (reg_addr == DSS_REG_IRQ_STAT) ? {12'h000, stat_q} :
                  (reg_addr == DSS_REG_IRQ_EN) ? {12'h000, en_q} :
                  (reg_addr == DSS_REG_RDBACK) ? {8'h00, rdback_q} :
                  (reg_addr == DSS_REG_DL_CFG) ? dl_cfg_q : 16'h0000;

  // set wins over clear on the sticky bits
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      skip_q <= 1'b0;
      dl_cfg_q <= DSS_DL_CFG_RST;
      en_q <= DSS_IRQ_EN_RST;
      stat_q <= '0;
      irq <= 1'b0;
      rdback_q <= 8'h00;
      reg_rdata <= 16'h0000;
    end
    else if (ce)
    begin
      if (reg_wr && reg_addr == DSS_REG_CTRL)
        skip_q <= reg_wdata[DSS_CTRL_SKIP_RST];
      if (reg_wr && reg_addr == DSS_REG_DL_CFG)
        dl_cfg_q <= reg_wdata;
      if (reg_wr && reg_addr == DSS_REG_IRQ_EN)
        en_q <= reg_wdata[DSS_NEV-1:0];
      stat_q <= (stat_q & ~clr_bits) | ev;
      irq <= |(stat_q & en_q);
      if (spi_done && req_q.rd)
        rdback_q <= spi_rdata;
      reg_rdata <= reg_rd ? rd_mux : 16'h0000;
    end

  dss_spi_master #(.HALF(SPI_HALF)) u_spi (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .go(go_q),
    .req(req_q),
    .busy(spi_busy),
    .done(spi_done),
    .rdata(spi_rdata),
    .sclk(spi_sclk),
    .cs_n(spi_cs_n),
    .mosi(spi_mosi),
    .miso(spi_miso)
  );

  dss_edge_timer #(.CW(CW)) u_tmr (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .link_clk(data_clk),
    .go(tgo_q),
    .count(wait_cnt),
    .done(tmr_done)
  );

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_step_at(logic [4:0] i);
    state_q == S_STEP && idx_q == i && ce;
  endsequence

  a_first_write: assert property (start_cmd && ce ##1 ce |=> go_q && !req_q.rd && req_q.wdata == DEV_SPCFG_4W_MSB && req_q.addr == DEV_SERIAL_PORT_CONFIG)
    else $error("first access is not the serial port write");
  a_reset_clear: assert property (s_step_at(DSS_IDX_SW_RESET + 5'h01) |=> go_q && req_q.wdata == DEV_SPCFG_4W_MSB)
    else $error("reset bit not cleared after software reset");
  a_reset_skip: assert property (s_step_at(DSS_IDX_SW_RESET) && skip_q |=> !go_q ##1 go_q)
    else $error("skipped software reset still issued");
  a_common_mode: assert property (s_step_at(DSS_IDX_CM_A) |=> go_q && req_q.addr == DEV_CLOCK_INPUT_COMMON_MODE_A && req_q.wdata == DEV_CM_VAL)
    else $error("common-mode write wrong");
  a_delay_cfg: assert property (s_step_at(DSS_IDX_DL_A) |=> go_q && req_q.wdata == dl_cfg_q[7:0])
    else $error("delay-lock configuration write wrong");
  a_lock_order: assert property (req_q.addr == DEV_RX_CTRL && go_q |-> idx_q > DSS_IDX_DL_RETRY + 5'h04)
    else $error("receiver enabled before delay-lock tracking");
  a_try_limit: assert property (tries_q < 2'(MAX_TRIES))
    else $error("attempt count beyond limit");
  a_phase_retry: assert property (state_q == S_PHW && spi_done && ce |=> idx_q == DSS_IDX_RX_RETRY && state_q == S_STEP)
    else $error("phase advance did not restart receiver");
  a_wait_lock: assert property (tgo_q && cur.op == OP_WAIT_DL |-> wait_cnt == CW'(DL_WAIT) && idx_q == DSS_IDX_DL_RETRY + 5'h03)
    else $error("delay-lock wait misplaced");
  a_dev_irq: assert property (ev[DSS_EV_DEV_IRQ] && ce |=> stat_q[DSS_EV_DEV_IRQ])
    else $error("device interrupt not latched");
endmodule
`default_nettype wire

// >>> design/dss_pkg.sv
package dss_pkg;

  // host register port offsets
  localparam logic [3:0] DSS_REG_CTRL = 4'h0;
  localparam logic [3:0] DSS_REG_STATUS = 4'h1;
  localparam logic [3:0] DSS_REG_IRQ_STAT = 4'h2;
  localparam logic [3:0] DSS_REG_IRQ_CLR = 4'h3;
  localparam logic [3:0] DSS_REG_IRQ_EN = 4'h4;
  localparam logic [3:0] DSS_REG_RDBACK = 4'h5;
  localparam logic [3:0] DSS_REG_DL_CFG = 4'h6;

  // field positions
  localparam int DSS_CTRL_START = 0;
  localparam int DSS_CTRL_SKIP_RST = 1;
  localparam int DSS_EV_DONE = 0;
  localparam int DSS_EV_DL_FAIL = 1;
  localparam int DSS_EV_RX_FAIL = 2;
  localparam int DSS_EV_DEV_IRQ = 3;
  localparam int DSS_NEV = 4;

  // reset values
  localparam logic [15:0] DSS_DL_CFG_RST = 16'h8030;
  localparam logic [DSS_NEV-1:0] DSS_IRQ_EN_RST = 4'h0;

  // device register offsets
  localparam logic [6:0] DEV_SERIAL_PORT_CONFIG = 7'h00;
  localparam logic [6:0] DEV_CLOCK_INPUT_COMMON_MODE_A = 7'h22;
  localparam logic [6:0] DEV_CLOCK_INPUT_COMMON_MODE_B = 7'h23;
  localparam logic [6:0] DEV_DELAY_LOCK_CONFIG_A = 7'h24;
  localparam logic [6:0] DEV_DELAY_LOCK_CONFIG_B = 7'h25;
  localparam logic [6:0] DEV_DELAY_LOCK_CTRL = 7'h26;
  localparam logic [6:0] DEV_DELAY_LOCK_TUNE_A = 7'h27;
  localparam logic [6:0] DEV_DELAY_LOCK_TUNE_B = 7'h28;
  localparam logic [6:0] DEV_DELAY_LOCK_TUNE_C = 7'h29;
  localparam logic [6:0] DEV_DELAY_LOCK_STATUS = 7'h2A;
  localparam logic [6:0] DEV_RX_SKEW = 7'h13;
  localparam logic [6:0] DEV_RX_CTRL = 7'h10;
  localparam logic [6:0] DEV_RX_STATUS = 7'h21;
  localparam logic [6:0] DEV_DIVIDER_PHASE = 7'h14;

  // device write and expected values
  localparam logic [7:0] DEV_SPCFG_4W_MSB = 8'h00;
  localparam logic [7:0] DEV_SPCFG_SW_RESET = 8'h20;
  localparam logic [7:0] DEV_CM_VAL = 8'h0F;
  localparam logic [7:0] DEV_TUNE_A_VAL = 8'h44;
  localparam logic [7:0] DEV_TUNE_B_VAL = 8'h6C;
  localparam logic [7:0] DEV_TUNE_C_VAL = 8'hCB;
  localparam logic [7:0] DEV_DL_LOOP_VAL = 8'h02;
  localparam logic [7:0] DEV_DL_TRACK_VAL = 8'h03;
  localparam logic [7:0] DEV_DL_LOCKED = 8'h01;
  localparam logic [7:0] DEV_RX_SKEW_VAL = 8'h72;
  localparam logic [7:0] DEV_RX_OFF_VAL = 8'h00;
  localparam logic [7:0] DEV_RX_LOOP_VAL = 8'h02;
  localparam logic [7:0] DEV_RX_TRACK_VAL = 8'h03;
  localparam logic [7:0] DEV_RX_LOCKED = 8'h09;

  // sequence positions
  localparam logic [4:0] DSS_IDX_SW_RESET = 5'h01;
  localparam logic [4:0] DSS_IDX_CM_A = 5'h03;
  localparam logic [4:0] DSS_IDX_DL_A = 5'h05;
  localparam logic [4:0] DSS_IDX_DL_RETRY = 5'h09;
  localparam logic [4:0] DSS_IDX_RX_RETRY = 5'h0F;

  // timing counts
  localparam int DSS_DL_WAIT_PERIODS = 160000;
  localparam int DSS_RX_WAIT_PERIODS = 135000;
  localparam int DSS_MAX_TRIES = 3;
  localparam int DSS_SPI_HALF = 4;
  localparam int DSS_WAIT_W = 18;

  typedef enum logic [2:0] {OP_WR, OP_WAIT_DL, OP_CHK_DL, OP_WAIT_RX, OP_CHK_RX, OP_END} dss_op_type;

  typedef struct packed {
    dss_op_type op;
    logic [6:0] addr;
    logic [7:0] data;
  } dss_step_type;

  typedef struct packed {
    logic rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } dss_spi_req_type;

endpackage

// >>> design/dss_spi_master.sv
`timescale 1ns/1ps
`default_nettype none
module dss_spi_master #(
  parameter int HALF = 4
) (
  input wire logic clk, // system clock
  input wire logic nrst, // async reset, low
  input wire logic ce, // clock enable
  input wire logic go, // start one frame
  input wire dss_pkg::dss_spi_req_type req, // frame contents
  output logic busy, // frame running
  output logic done, // frame finished pulse
  output logic [7:0] rdata, // byte read back
  output logic sclk, // serial clock
  output logic cs_n, // chip select, low
  output logic mosi, // serial data out
  input wire logic miso // serial data in
);
  import dss_pkg::*;

  logic miso_s1_q, miso_s2_q;
  logic [$clog2(HALF)-1:0] div_q;
  logic [4:0] bit_q;
  logic [15:0] sh_q;
  logic tick;

  // miso is synchronised, so a bit must be stable two cycles before the rise
  if (HALF < 3) $error("HALF too small for synchronised sampling");

  assign tick = (div_q == ($clog2(HALF))'(HALF - 1));

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      miso_s1_q <= 1'b0;
      miso_s2_q <= 1'b0;
    end
    else if (ce)
    begin
      miso_s1_q <= miso;
      miso_s2_q <= miso_s1_q;
    end

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      div_q <= '0;
      bit_q <= 5'h00;
      sh_q <= 16'h0000;
      rdata <= 8'h00;
      sclk <= 1'b0;
      cs_n <= 1'b1;
      mosi <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
    end
    else if (ce)
    begin
      done <= 1'b0;
      if (!busy)
      begin
        if (go)
        begin
          busy <= 1'b1;
          cs_n <= 1'b0;
          sh_q <= req;
          mosi <= req.rd;
          bit_q <= 5'h10;
          div_q <= '0;
        end
      end
      else
      begin
        div_q <= tick ? '0 : div_q + 1'b1;
        if (tick && !sclk)
        begin
          sclk <= 1'b1;
          rdata <= {rdata[6:0], miso_s2_q};
        end
        else if (tick)
        begin
          sclk <= 1'b0;
          if (bit_q == 5'h01)
          begin
            busy <= 1'b0;
            cs_n <= 1'b1;
            done <= 1'b1;
          end
          else
          begin
            bit_q <= bit_q - 5'h01;
            sh_q <= {sh_q[14:0], 1'b0};
            mosi <= sh_q[14];
          end
        end
      end
    end

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  a_cs_frame: assert property (!busy |-> cs_n && !sclk)
    else $error("chip select or clock active outside a frame");
endmodule
`default_nettype wire

// >>> design/dss_edge_timer.sv
`timescale 1ns/1ps
`default_nettype none
module dss_edge_timer #(
  parameter int CW = 18
) (
  input wire logic clk, // system clock
  input wire logic nrst, // async reset, low
  input wire logic ce, // clock enable
  input wire logic link_clk, // data clock from the link
  input wire logic go, // start a wait
  input wire logic [CW-1:0] count, // periods to wait
  output logic done // wait over pulse
);
  import dss_pkg::*;

  logic lk_s1_q, lk_s2_q, lk_s3_q;
  logic run_q;
  logic [CW-1:0] cnt_q;
  logic lk_rise;

  assign lk_rise = lk_s2_q && !lk_s3_q;

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      lk_s1_q <= 1'b0;
      lk_s2_q <= 1'b0;
      lk_s3_q <= 1'b0;
    end
    else if (ce)
    begin
      lk_s1_q <= link_clk;
      lk_s2_q <= lk_s1_q;
      lk_s3_q <= lk_s2_q;
    end

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      run_q <= 1'b0;
      cnt_q <= '0;
      done <= 1'b0;
    end
    else if (ce)
    begin
      done <= 1'b0;
      if (go)
      begin
        run_q <= 1'b1;
        cnt_q <= count;
      end
      else if (run_q && lk_rise)
      begin
        cnt_q <= cnt_q - 1'b1;
        if (cnt_q == CW'(1))
        begin
          run_q <= 1'b0;
          done <= 1'b1;
        end
      end
    end

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  a_wait_edges: assert property (run_q && !lk_rise && !go && ce |=> cnt_q == $past(cnt_q))
    else $error("wait counter moved without a data clock edge");
endmodule
`default_nettype wire

// >>> tb/dss_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module dss_dev_model (
  input wire logic nrst, // reset, low
  input wire logic sclk, // serial clock from host
  input wire logic cs_n, // select, low
  input wire logic mosi, // data from host
  output logic miso, // data to host
  output logic irq_n, // interrupt pin, low
  input wire logic [1:0] dl_fails, // delay-lock reads that fail
  input wire logic [1:0] rx_fails // receiver reads that fail
);
  logic [7:0] regs [0:127];
  logic [7:0] rbyte;
  logic [15:0] sh;
  logic [15:0] log_q [$];
  logic rd;
  int nbit;
  int dl_n;
  int rx_n;
  task clear;
    foreach (regs[i]) regs[i] = 8'h00;
    dl_n = 0;
    rx_n = 0;
    irq_n = 1'b1;
    miso = 1'b0;
    nbit = 0;
    rd = 1'b0;
    log_q.delete();
  endtask
  initial clear();
  always @(negedge nrst) clear();
  always @(negedge cs_n)
  begin
    nbit = 0;
    miso = ~miso;
  end
  always @(posedge sclk)
    if (!cs_n)
    begin
      sh = {sh[14:0], mosi};
      nbit++;
    end
  // released line toggles so a stale value never reads as data
  always @(negedge sclk)
  begin
    if (!cs_n && nbit == 8)
    begin
      rd = sh[7];
      rbyte = regs[sh[6:0]];
      if (sh[6:0] == 7'h2A)
      begin
        rbyte = (dl_n < int'(dl_fails)) ? 8'h00 : 8'h01;
        dl_n++;
      end
      if (sh[6:0] == 7'h21)
      begin
        rbyte = (rx_n < int'(rx_fails)) ? 8'h08 : 8'h09;
        rx_n++;
        if (rbyte == 8'h09) irq_n = 1'b0;
      end
    end
    miso = (!cs_n && rd && nbit >= 8 && nbit < 16) ? rbyte[3'(15 - nbit)] : ~miso;
  end
  always @(posedge cs_n)
    if (nbit == 16)
    begin
      rd = 1'b0;
      if (sh[15]) log_q.push_back({sh[15:8], 8'h00});
      else
      begin
        log_q.push_back(sh);
        if (sh[14:8] == 7'h00 && sh[5]) foreach (regs[i]) regs[i] = 8'h00;
        else regs[sh[14:8]] = sh[7:0];
      end
    end
endmodule
`default_nettype wire

// >>> tb/dss_startup_host_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dss_startup_host_tb;
  import dss_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, ce = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, data_clk = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, rv;
  logic irq, sclk, cs_n, mosi, miso, irq_n;
  logic [1:0] dl_fails = 2'h0, rx_fails = 2'h0;
  logic [15:0] exp_q [$];
  int err_count = 0, tests_run = 0, cyc = 0;
  initial forever #12.5 clk = ~clk;
  initial forever #100 data_clk = ~data_clk;
  dss_startup_host #(.DL_WAIT(20), .RX_WAIT(20)) dut (.clk(clk), .nrst(nrst), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .spi_sclk(sclk),
    .spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso(miso), .data_clk(data_clk), .dev_irq_n(irq_n));
  dss_dev_model dev (.nrst(nrst), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso), .irq_n(irq_n),
    .dl_fails(dl_fails), .rx_fails(rx_fails));
  task summarize;
    $display("tests_run=%0d err_count=%0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      err_count++;
      summarize();
    end
  end
  task chk(input string what, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task rchk(input string what, input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
    rd(a, rv);
    chk(what, e, rv & m);
  endtask
  task do_reset;
    nrst <= 1'b0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
  endtask
  task ew(input logic rdf, input logic [6:0] a, input logic [7:0] d);
    exp_q.push_back({rdf, a, d});
  endtask
  task build(input logic skip, input logic [15:0] cfg, input int dlf, input int rxf);
    logic [7:0] ph;
    ph = 8'h00;
    exp_q.delete();
    // single device, no sync controller frames
    ew(0, 7'h00, 8'h00);
    if (!skip) ew(0, 7'h00, 8'h20);
    ew(0, 7'h00, 8'h00);
    ew(0, 7'h22, 8'h0F);
    ew(0, 7'h23, 8'h0F);
    ew(0, 7'h24, cfg[7:0]);
    ew(0, 7'h25, cfg[15:8]);
    ew(0, 7'h27, 8'h44);
    ew(0, 7'h28, 8'h6C);
    for (int i = 0; i < 3; i++)
    begin
      ew(0, 7'h29, 8'hCB);
      ew(0, 7'h26, 8'h02);
      ew(0, 7'h26, 8'h03);
      ew(1, 7'h2A, 8'h00);
      if (i >= dlf) break;
    end
    if (dlf < 3) ew(0, 7'h13, 8'h72);
    for (int i = 0; i < 3 && dlf < 3; i++)
    begin
      ew(0, 7'h10, 8'h00);
      ew(0, 7'h10, 8'h02);
      ew(0, 7'h10, 8'h03);
      ew(1, 7'h21, 8'h00);
      if (i >= rxf) break;
      ew(1, 7'h14, 8'h00);
      ph = ph + 8'h40;
      ew(0, 7'h14, ph);
    end
  endtask
  // frames on the wire against the expected order
  task run_chk(input logic [15:0] st);
    int n;
    n = 0;
    rv = 16'h0001;
    while (rv[0] !== 1'b0 && n < 8000)
    begin
      rd(DSS_REG_STATUS, rv);
      n++;
    end
    chk("status", st, rv & 16'h000F);
    chk("frame count", 16'(exp_q.size()), 16'(dev.log_q.size()));
    foreach (exp_q[i]) chk("frame", exp_q[i], (i < dev.log_q.size()) ? dev.log_q[i] : 16'hFFFF);
  endtask
  initial
  begin
    do_reset();
    rchk("dl cfg", DSS_REG_DL_CFG, 16'hFFFF, 16'h8030);
    rchk("irq en", DSS_REG_IRQ_EN, 16'hFFFF, 16'h0000);
    rchk("irq stat", DSS_REG_IRQ_STAT, 16'hFFFF, 16'h0000);
    rchk("unmapped", 4'hF, 16'hFFFF, 16'h0000);
    $display("test reset values done");
    wr(DSS_REG_IRQ_EN, 16'h000F);
    wr(DSS_REG_CTRL, 16'h0001);
    wr(DSS_REG_CTRL, 16'h0001);
    build(1'b0, 16'h8030, 0, 0);
    run_chk(16'h0002);
    rchk("irq stat", DSS_REG_IRQ_STAT, 16'hFFFF, 16'h0009);
    rchk("readback", DSS_REG_RDBACK, 16'h00FF, 16'h0009);
    chk("irq", 16'h0001, {15'h0000, irq});
    wr(DSS_REG_IRQ_CLR, 16'h000F);
    rchk("irq stat", DSS_REG_IRQ_STAT, 16'hFFFF, 16'h0000);
    chk("irq", 16'h0000, {15'h0000, irq});
    $display("test default sequence done");
    dl_fails <= 2'h1;
    rx_fails <= 2'h2;
    do_reset();
    wr(DSS_REG_DL_CFG, 16'h1234);
    wr(DSS_REG_CTRL, 16'h0003);
    build(1'b1, 16'h1234, 1, 2);
    run_chk(16'h0002);
    chk("irq masked", 16'h0000, {15'h0000, irq});
    $display("test retries done");
    dl_fails <= 2'h3;
    rx_fails <= 2'h0;
    do_reset();
    wr(DSS_REG_IRQ_EN, 16'h0002);
    wr(DSS_REG_CTRL, 16'h0001);
    build(1'b0, 16'h8030, 3, 0);
    run_chk(16'h0004);
    rchk("irq stat", DSS_REG_IRQ_STAT, 16'hFFFF, 16'h0002);
    chk("irq", 16'h0001, {15'h0000, irq});
    $display("test lock failure done");
    summarize();
  end
endmodule
`default_nettype wire
